// ### logic/tcs_timer_count_clock_select.sv
// count clock source and edge selection for timer channels 0 to 3
`timescale 1ns/100ps

module tcs_timer_count_clock_select
   import tcs_pkg::*;
(
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // count sources
   input wire logic [NUM_EXT-1:0] extCountPin,
   input wire logic channel2WrapPulse,
   // count enables to the channel counters
   output logic [NUM_CH-1:0] countTick
);

   // ****************************************
   // declarations
   // ****************************************
   logic [CTRL_W-1:0] ctrl_reg [NUM_CH];
   logic [CTRL_W-1:0] ctrl_next [NUM_CH];
   logic [1:0] phase_reg;
   logic [1:0] phase_next;
   logic wrPend_reg;
   logic wrPend_next;
   logic [ADDR_DECODE_W-1:0] addr_reg;
   logic [ADDR_DECODE_W-1:0] addr_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [PRESCALE_W-1:0] prescale_reg;
   logic [PRESCALE_W-1:0] prescale_next;
   logic [NUM_DIV-1:0] divPrev_reg;
   logic [NUM_DIV-1:0] divLvl;
   logic [NUM_DIV-1:0] divRise;
   logic [NUM_DIV-1:0] divFall;
   logic [NUM_EXT-1:0] extMeta_reg;
   logic [NUM_EXT-1:0] extSync_reg;
   logic [NUM_EXT-1:0] extPrev_reg;
   logic [NUM_EXT-1:0] extRise;
   logic [NUM_EXT-1:0] extFall;
   logic [NUM_CH-1:0] tick_reg;
   logic [NUM_CH-1:0] tick_next;
   logic take;

   // ****************************************
   // source decode per channel
   // ****************************************
   function automatic logic [4:0] decodeSource(input logic [1:0] ch, input logic [2:0] code);
      tcs_src_t src;
      logic [1:0] pin;
      src = SRC_DIV1;
      pin = 2'h0;
      case (ch)
         2'h0: begin
            if (code[2]) begin
               src = SRC_EXT;
               pin = code[1:0];
            end else begin
               src = tcs_src_t'(code);
            end
         end
         2'h1: begin
            case (code)
               3'h4: src = SRC_EXT;
               3'h5: begin
                  src = SRC_EXT;
                  pin = 2'h1;
               end
               3'h6: src = SRC_DIV256;
               3'h7: src = SRC_CASCADE;
               default: src = tcs_src_t'(code);
            endcase
         end
         2'h2: begin
            case (code)
               3'h4: src = SRC_EXT;
               3'h5: begin
                  src = SRC_EXT;
                  pin = 2'h1;
               end
               3'h6: begin
                  src = SRC_EXT;
                  pin = 2'h2;
               end
               3'h7: src = SRC_DIV1024;
               default: src = tcs_src_t'(code);
            endcase
         end
         default: begin
            case (code)
               3'h4: src = SRC_DIV256;
               3'h5: src = SRC_DIV1024;
               3'h6: src = SRC_EXT;
               3'h7: begin
                  src = SRC_EXT;
                  pin = 2'h1;
               end
               default: src = tcs_src_t'(code);
            endcase
         end
      endcase
      return {src, pin};
   endfunction

   function automatic logic [31:0] readMux(input logic [ADDR_DECODE_W-1:0] a,
                                           input logic [CTRL_W-1:0] c0,
                                           input logic [CTRL_W-1:0] c1,
                                           input logic [CTRL_W-1:0] c2,
                                           input logic [CTRL_W-1:0] c3,
                                           input logic [1:0] ph,
                                           input logic [NUM_EXT-1:0] pins,
                                           input logic [NUM_CH-1:0] ticks);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         ADDR_CTRL0: d = {24'h00_0000, c0};
         ADDR_CTRL1: d = {24'h00_0000, c1};
         ADDR_CTRL2: d = {24'h00_0000, c2};
         ADDR_CTRL3: d = {24'h00_0000, c3};
         ADDR_PHASE: d = {30'h0000_0000, ph};
         ADDR_STATUS: d = {24'h00_0000, ticks, pins};
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   // ****************************************
   // bus slave and control registers
   // ****************************************
   assign take = hsel & htrans[1] & hready & ce;

   always_comb begin
      wrPend_next = take & hwrite;
      addr_next = take ? haddr[ADDR_DECODE_W-1:0] : addr_reg;
      phase_next = phase_reg;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         ctrl_next[ch] = ctrl_reg[ch];
      end
      if (wrPend_reg) begin
         case (addr_reg)
            ADDR_CTRL0: ctrl_next[0] = hwdata[7:0] & CTRL_MASK_FULL;
            ADDR_CTRL1: ctrl_next[1] = hwdata[7:0] & CTRL_MASK_CH12;
            ADDR_CTRL2: ctrl_next[2] = hwdata[7:0] & CTRL_MASK_CH12;
            ADDR_CTRL3: ctrl_next[3] = hwdata[7:0] & CTRL_MASK_FULL;
            ADDR_PHASE: phase_next = hwdata[1:0];
            default: phase_next = phase_reg;
         endcase
      end
      rdata_next = rdata_reg;
      if (take && !hwrite) begin
         rdata_next = readMux(haddr[ADDR_DECODE_W-1:0], ctrl_next[0], ctrl_next[1],
                              ctrl_next[2], ctrl_next[3], phase_next, extSync_reg, tick_reg);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            ctrl_reg[ch] <= CTRL_RESET;
         end
         phase_reg <= PHASE_RESET;
         wrPend_reg <= 1'b0;
         addr_reg <= 8'h00;
         rdata_reg <= 32'h0000_0000;
      end else if (ce) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            ctrl_reg[ch] <= ctrl_next[ch];
         end
         phase_reg <= phase_next;
         wrPend_reg <= wrPend_next;
         addr_reg <= addr_next;
         rdata_reg <= rdata_next;
      end
   end

   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   // ****************************************
   // prescaler and pin synchronisers
   // ****************************************
   always_comb begin
      prescale_next = prescale_reg + 10'h001;
      divLvl = {prescale_reg[TAP_DIV1024], prescale_reg[TAP_DIV256], prescale_reg[TAP_DIV64],
                prescale_reg[TAP_DIV16], prescale_reg[TAP_DIV4]};
      divRise = divLvl & ~divPrev_reg;
      divFall = ~divLvl & divPrev_reg;
      extRise = extSync_reg & ~extPrev_reg;
      extFall = ~extSync_reg & extPrev_reg;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prescale_reg <= PRESCALE_RESET;
         divPrev_reg <= 5'h00;
         extMeta_reg <= 4'h0;
         extSync_reg <= 4'h0;
         extPrev_reg <= 4'h0;
      end else if (ce) begin
         prescale_reg <= prescale_next;
         divPrev_reg <= divLvl;
         extMeta_reg <= extCountPin;
         extSync_reg <= extMeta_reg;
         extPrev_reg <= extSync_reg;
      end
   end

   // ****************************************
   // edge selection and count enables
   // ****************************************
   always_comb begin
      logic [4:0] dec;
      tcs_src_t src;
      logic rise;
      logic fall;
      logic forced;
      logic [1:0] edgeSel;
      dec = 5'h00;
      src = SRC_DIV1;
      rise = 1'b0;
      fall = 1'b0;
      forced = 1'b0;
      edgeSel = EDGE_RISE;
      tick_next = 4'h0;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         dec = decodeSource(2'(ch), ctrl_reg[ch][SRC_MSB:SRC_LSB]);
         src = tcs_src_t'(dec[4:2]);
         edgeSel = ctrl_reg[ch][EDGE_MSB:EDGE_LSB];
         case (src)
            SRC_DIV1: begin
               rise = 1'b1;
               fall = 1'b0;
               forced = 1'b1;
            end
            SRC_EXT: begin
               rise = extRise[dec[1:0]];
               fall = extFall[dec[1:0]];
               forced = 1'b0;
            end
            SRC_CASCADE: begin
               rise = channel2WrapPulse;
               fall = 1'b0;
               forced = 1'b1;
            end
            default: begin
               rise = divRise[3'(src) - 3'h1];
               fall = divFall[3'(src) - 3'h1];
               forced = 1'b0;
            end
         endcase
         if (forced || edgeSel == EDGE_RISE) begin
            tick_next[ch] = rise;
         end else if (edgeSel == EDGE_FALL) begin
            tick_next[ch] = fall;
         end else if (edgeSel[EDGE_BOTH_BIT]) begin
            tick_next[ch] = rise | fall;
         end else begin
            tick_next[ch] = rise;
         end
      end
      if (phase_reg[PHASE_CH1_BIT]) begin
         tick_next[1] = 1'b0;
      end
      if (phase_reg[PHASE_CH2_BIT]) begin
         tick_next[2] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_reg <= 4'h0;
      end else if (ce) begin
         tick_reg <= tick_next;
      end
   end

   assign countTick = tick_reg;

endmodule

// ### logic/tcs_pkg.sv
// constants for the timer count clock select block
package tcs_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] ADDR_CTRL1 = 8'h04;
   localparam logic [7:0] ADDR_CTRL2 = 8'h08;
   localparam logic [7:0] ADDR_CTRL3 = 8'h0C;
   localparam logic [7:0] ADDR_PHASE = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam int unsigned ADDR_DECODE_W = 8;

   // ****************************************
   // field layout and reset values
   // ****************************************
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned CTRL_W = 8;
   localparam int unsigned SRC_LSB = 0;
   localparam int unsigned SRC_MSB = 2;
   localparam int unsigned EDGE_LSB = 3;
   localparam int unsigned EDGE_MSB = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_MASK_FULL = 8'hFF;
   localparam logic [7:0] CTRL_MASK_CH12 = 8'h7F;
   localparam logic [1:0] PHASE_RESET = 2'h0;
   localparam int unsigned PHASE_CH1_BIT = 0;
   localparam int unsigned PHASE_CH2_BIT = 1;
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam int unsigned EDGE_BOTH_BIT = 1;

   // ****************************************
   // prescaler taps
   // ****************************************
   localparam int unsigned PRESCALE_W = 10;
   localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 10'h000;
   localparam int unsigned NUM_DIV = 5;
   localparam int unsigned TAP_DIV4 = 1;
   localparam int unsigned TAP_DIV16 = 3;
   localparam int unsigned TAP_DIV64 = 5;
   localparam int unsigned TAP_DIV256 = 7;
   localparam int unsigned TAP_DIV1024 = 9;
   localparam int unsigned NUM_EXT = 4;

   // ****************************************
   // count source kinds
   // ****************************************
   typedef enum logic [2:0] {
      SRC_DIV1 = 3'b000,
      SRC_DIV4 = 3'b001,
      SRC_DIV16 = 3'b010,
      SRC_DIV64 = 3'b011,
      SRC_DIV256 = 3'b100,
      SRC_DIV1024 = 3'b101,
      SRC_EXT = 3'b110,
      SRC_CASCADE = 3'b111
   } tcs_src_t;

endpackage

// ### sim/tcs_properties.sv
// port assertions for the count clock select block
`timescale 1ns/100ps
module tcs_properties
   import tcs_pkg::*;
(
   // clock and bus
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // count path
   input wire logic channel2WrapPulse,
   input wire logic [3:0] countTick
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic take, rdTake, wrReg, live;
   logic [7:0] addrReg;
   logic [2:0] src0Reg, src1Reg;
   logic [1:0] phaseReg;
   assign take = hsel && htrans[1] && hreadyout && ce;
   assign rdTake = take && !hwrite;
   // shadow of the written source and phase fields
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         live <= 1'b0;
         wrReg <= 1'b0;
         addrReg <= 8'h00;
         src0Reg <= 3'h0;
         src1Reg <= 3'h0;
         phaseReg <= 2'h0;
      end else if (ce) begin
         live <= 1'b1;
         wrReg <= take && hwrite;
         addrReg <= haddr[7:0];
         if (wrReg && addrReg == ADDR_CTRL0) src0Reg <= hwdata[2:0];
         if (wrReg && addrReg == ADDR_CTRL1) src1Reg <= hwdata[2:0];
         if (wrReg && addrReg == ADDR_PHASE) phaseReg <= hwdata[1:0];
      end
   end
   // ******************
   // properties
   // ******************
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_ready; hreadyout == ce; endproperty
   a_ready: assert property (p_ready) else $error("ready differs from enable");
   property p_rd_hold; !rdTake |=> $stable(hrdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_upper; rdTake |=> hrdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_unmapped; rdTake && haddr[7:2] > 6'h05 |=> hrdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_freeze; !ce |=> $stable(countTick); endproperty
   a_freeze: assert property (p_freeze) else $error("ticks moved while stalled");
   property p_div1;
      $past(live) && $past(ce) && $past(src0Reg) == 3'h0 |-> countTick[0];
   endproperty
   a_div1: assert property (p_div1) else $error("undivided source missed a tick");
   property p_wrap;
      $past(live) && $past(ce) && $past(src1Reg) == 3'h7 && !$past(phaseReg[0])
         |-> countTick[1] == $past(channel2WrapPulse);
   endproperty
   a_wrap: assert property (p_wrap) else $error("cascade tick wrong");
   property p_phase1;
      $past(live) && $past(ce) && $past(phaseReg[0]) |-> !countTick[1];
   endproperty
   a_phase1: assert property (p_phase1) else $error("channel 1 ticked in phase mode");
   property p_phase2;
      $past(live) && $past(ce) && $past(phaseReg[1]) |-> !countTick[2];
   endproperty
   a_phase2: assert property (p_phase2) else $error("channel 2 ticked in phase mode");
   c_write: cover property (take && hwrite);
   c_cascade: cover property (countTick[1] && src1Reg == 3'h7);
   c_phase: cover property (live && phaseReg == 2'h3);
endmodule

// ### sim/tcs_pin_model.sv
// external count pins and channel 2 wrap source
`timescale 1ns/100ps
module tcs_pin_model
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // selection from the bench
   input wire logic [3:0] pinEnable,
   input wire logic wrapEnable,
   // toward the block
   output logic [3:0] extCountPin,
   output logic channel2WrapPulse
);
   logic [4:0] phaseCnt;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) phaseCnt <= 5'h00;
      else phaseCnt <= phaseCnt + 5'h01;
   end
   // enabled pins square wave of period 16, others held low
   assign extCountPin = pinEnable & {4{phaseCnt[3]}};
   // one wrap pulse every 32 cycles
   assign channel2WrapPulse = wrapEnable && (phaseCnt == 5'h1F);
endmodule

// ### sim/tcs_testbench.sv
// self-checking bench for the count clock select block
`timescale 1ns/100ps
module testbench
   import tcs_pkg::*;
;
   localparam int W = 2048;
   logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, wrapEn = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [3:0] pinEn = 4'h0, extCountPin, countTick;
   logic hreadyout, hresp, channel2WrapPulse;
   logic [31:0] cnt [4];
   int num_errors = 0, total_checks = 0;
   // channel, pins, wrap, control byte, expected ticks in the window
   logic [31:0] tbl [23] = '{32'h0_0_0_01_200, 32'h0_0_0_0A_080, 32'h0_0_0_13_040,
      32'h0_1_0_04_080, 32'h0_2_0_05_080, 32'h0_4_0_06_080, 32'h0_8_0_1F_100,
      32'h1_0_0_06_008, 32'h1_1_0_04_080, 32'h1_2_0_0D_080, 32'h1_0_1_1F_040,
      32'h1_0_0_18_800, 32'h2_0_0_07_002, 32'h2_1_0_04_080, 32'h2_2_0_05_080,
      32'h2_4_0_06_080, 32'h3_0_0_04_008, 32'h3_0_0_0D_002, 32'h3_1_0_0E_080,
      32'h3_2_0_07_080, 32'h1_0_0_02_080, 32'h2_0_0_0B_020, 32'h3_0_0_11_400};
   always #5 sys_clk = ~sys_clk;
   tcs_timer_count_clock_select i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .extCountPin(extCountPin), .channel2WrapPulse(channel2WrapPulse), .countTick(countTick));
   tcs_pin_model i_pins (.sys_clk(sys_clk), .rst(rst), .pinEnable(pinEn), .wrapEnable(wrapEn),
      .extCountPin(extCountPin), .channel2WrapPulse(channel2WrapPulse));
   // ******************
   // tasks
   // ******************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic measure;
      repeat (8) @(posedge sys_clk);
      cnt = '{default: 32'h0};
      repeat (W) begin
         @(posedge sys_clk);
         for (int k = 0; k < 4; k++) cnt[k] += 32'(countTick[k]);
      end
   endtask
   task automatic check_regs;
      bus(1'b1, 8'h18, 32'hFF);
      for (int a = 0; a < 7; a++) begin
         bus(1'b0, 8'(a * 4), 32'h0);
         check(rd, (a == 5) ? 32'hF0 : 32'h0);
      end
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 8'(c * 4), 32'hFF);
         bus(1'b0, 8'(c * 4), 32'h0);
         check(rd, (c == 1 || c == 2) ? 32'h7F : 32'hFF);
         bus(1'b1, 8'(c * 4), 32'h0);
      end
   endtask
   task automatic check_stall;
      ce <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check({31'h0, hreadyout}, 32'h0);
      ce <= 1'b1;
      @(posedge sys_clk);
   endtask
   task automatic check_sources;
      logic [31:0] e;
      for (int i = 0; i < 23; i++) begin
         e = tbl[i];
         pinEn <= e[27:24];
         wrapEn <= e[20];
         bus(1'b1, {4'h0, e[29:28], 2'h0}, {24'h0, e[19:12]});
         measure;
         for (int k = 0; k < 4; k++) begin
            check(cnt[k], (k == e[31:28]) ? {20'h0, e[11:0]} : 32'(W));
         end
         bus(1'b1, {4'h0, e[29:28], 2'h0}, 32'h0);
      end
   endtask
   task automatic check_phase;
      bus(1'b1, ADDR_PHASE, 32'h3);
      bus(1'b1, ADDR_CTRL1, 32'h1F);
      bus(1'b1, ADDR_CTRL2, 32'h13);
      wrapEn <= 1'b1;
      measure;
      check(cnt[0], 32'(W));
      check(cnt[1], 32'h0);
      check(cnt[2], 32'h0);
      check(cnt[3], 32'(W));
      bus(1'b1, ADDR_PHASE, 32'h0);
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check_regs;
      check_stall;
      check_sources;
      check_phase;
      wrap_up;
   end
   initial begin
      repeat (80000) @(posedge sys_clk);
      num_errors++;
      wrap_up;
   end
endmodule
bind tcs_timer_count_clock_select tcs_properties i_props (.sys_clk(sys_clk), .rst(rst),
   .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .channel2WrapPulse(channel2WrapPulse), .countTick(countTick));
